// ==== iafc_buf_if.sv ====
// Purpose: link between the control logic and its write buffer
// Assumes: one clock domain
// Notes:   read data is registered inside the buffer
interface iafc_buf_if #(parameter int DW = 16, parameter int IW = 6);
  logic load;
  logic [IW-1:0] load_idx;
  logic [DW-1:0] load_data;
  logic clear;
  logic [IW-1:0] rd_idx;
  logic [DW-1:0] rd_data;
  modport ctrl (output load, load_idx, load_data, clear, rd_idx, input rd_data);
  modport store (input load, load_idx, load_data, clear, rd_idx, output rd_data);
endinterface

// ==== iafc_ctrl.sv ====
// Purpose: register file, unlock procedure and flash operation sequencer
// Assumes: partner array is on i_core_clk and answers each request with one
//          done pulse; subsystem clock arrives as a plain level input
// Notes:   register reads return data one cycle after the read strobe
module iafc_ctrl #(
  parameter int ADDR_W = iafc_pkg::ADDR_W,
  parameter int DATA_W = iafc_pkg::DATA_W,
  parameter int BUF_DEPTH = iafc_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // data memory port
  input wire logic [7:0] i_mem_sector,
  input wire logic [7:0] i_mem_addr,
  input wire logic i_mem_wr,
  input wire logic i_mem_rd,
  input wire logic [7:0] i_mem_wdata,
  output logic [7:0] o_mem_rdata,
  output logic o_mem_hit,
  // subsystem clock for the unlock timeout
  input wire logic i_sub_clk,
  // flash array side
  output logic o_flash_req,
  output iafc_pkg::iafc_op_e o_flash_op,
  output logic [ADDR_W-1:0] o_flash_addr,
  input wire logic i_flash_done,
  input wire logic [DATA_W-1:0] i_flash_rdata,
  input wire logic [$clog2(BUF_DEPTH)-1:0] i_flash_buf_idx,
  output logic [DATA_W-1:0] o_flash_buf_data,
  // status and chip reset
  output logic o_write_enabled,
  output logic o_chip_rst
);
  import iafc_pkg::*;

  localparam int IW = $clog2(BUF_DEPTH);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic wen;
    logic [2:0] mode;
    logic pen;
    logic wt;
    logic rden;
    logic rd;
    logic [7:0] chip_key;
    logic buffer_clear_start;
    logic [ADDR_W-1:0] addr;
    logic [3:0][DATA_W-1:0] word;
    iafc_st_e st;
    iafc_op_e op;
    logic [ADDR_W-1:0] faddr;
    logic [TMO_W-1:0] tmo_cnt;
    logic [2:0] pat_idx;
    logic pat_bad;
    logic [7:0] rdata;
    logic hit;
    logic chip_rst;
    logic sync1;
    logic sync2;
    logic sync3;
  } iafc_ctrl_s;

  iafc_ctrl_s q_r;
  iafc_ctrl_s q_nxt;

  iafc_buf_if #(.DW(DATA_W), .IW(IW)) wbuf_bus ();

  iafc_wbuf #(
    .DW(DATA_W),
    .DEPTH(BUF_DEPTH),
    .IW(IW)
  ) u_wbuf (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .bus(wbuf_bus)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] read_mux(input iafc_ctrl_s s, input logic [3:0] idx);
    logic [7:0] v;
    v = RST_BYTE;
    case (idx)
      IDX_CTL: v = {s.wen, s.mode, s.pen, s.wt, s.rden, s.rd};
      IDX_CHIPRST: v = s.chip_key;
      IDX_BUFCLR: v = {7'h00, s.buffer_clear_start};
      IDX_ADDR_LO: v = s.addr[7:0];
      IDX_ADDR_HI: v = {1'b0, s.addr[ADDR_W-1:8]};
      default: begin
        if (idx >= IDX_W0_LO && idx <= IDX_W3_HI) begin
          v = s.word[3'(idx - IDX_W0_LO) >> 1][(idx[0] == IDX_W0_LO[0]) ? 0 : 8 +: 8];
        end
      end
    endcase
    return v;
  endfunction

  function automatic logic [ADDR_W-1:0] page_base(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:PAGE_LSB], {PAGE_LSB{1'b0}}};
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic wr_hit;
  logic rd_hit;
  logic [3:0] widx;
  logic sub_tick;
  logic unlock_run;
  logic [2:0] pk;
  logic can_write;

  always_comb begin
    q_nxt = q_r;
    wr_hit = i_mem_wr && reg_hit(i_mem_sector, i_mem_addr);
    rd_hit = i_mem_rd && reg_hit(i_mem_sector, i_mem_addr);
    widx = reg_idx(i_mem_addr);
    pk = 3'(widx - IDX_W1_LO);
    can_write = q_r.wen;

    wbuf_bus.load = 1'b0;
    wbuf_bus.load_idx = q_r.addr[IW-1:0];
    wbuf_bus.load_data = {i_mem_wdata, q_r.word[0][7:0]};
    wbuf_bus.clear = 1'b0;
    wbuf_bus.rd_idx = i_flash_buf_idx;

    // synchroniser; the second and third stages feed the edge detector
    q_nxt.sync1 = i_sub_clk;
    q_nxt.sync2 = q_r.sync1;
    q_nxt.sync3 = q_r.sync2;
    sub_tick = q_r.sync2 && !q_r.sync3;

    q_nxt.chip_rst = 1'b0;
    q_nxt.hit = rd_hit;
    if (rd_hit) begin
      q_nxt.rdata = read_mux(q_r, widx);
    end

    // --------------------------------------------------------------
    // unlock timeout on the subsystem clock
    // --------------------------------------------------------------
    unlock_run = q_r.pen && (q_r.mode == MODE_UNLOCK);
    if (unlock_run && sub_tick) begin
      if (q_r.tmo_cnt == TMO_W'(TMO_TICKS - 1)) begin
        q_nxt.pen = 1'b0;
        q_nxt.tmo_cnt = '0;
      end else begin
        q_nxt.tmo_cnt = TMO_W'(q_r.tmo_cnt + 1'b1);
      end
    end

    // --------------------------------------------------------------
    // software writes
    // --------------------------------------------------------------
    if (wr_hit) begin
      case (widx)
        IDX_CTL: begin
          if (!i_mem_wdata[BIT_WEN]) begin
            q_nxt.wen = 1'b0;
          end
          q_nxt.mode = i_mem_wdata[BIT_MODE_HI:BIT_MODE_LO];
          q_nxt.rden = i_mem_wdata[BIT_RDEN];
          if (i_mem_wdata[BIT_PEN] && !q_r.pen) begin
            q_nxt.pen = 1'b1;
            q_nxt.tmo_cnt = '0;
            q_nxt.pat_idx = '0;
            q_nxt.pat_bad = 1'b0;
          end else if (!i_mem_wdata[BIT_PEN]) begin
            q_nxt.pen = 1'b0;
          end
          if (i_mem_wdata[BIT_WT] && q_r.st == IAFC_ST_IDLE && can_write
              && (i_mem_wdata[BIT_MODE_HI:BIT_MODE_LO] == MODE_WRITE
              || i_mem_wdata[BIT_MODE_HI:BIT_MODE_LO] == MODE_ERASE)) begin
            q_nxt.wt = 1'b1;
            q_nxt.st = IAFC_ST_BUSY;
            q_nxt.op = (i_mem_wdata[BIT_MODE_HI:BIT_MODE_LO] == MODE_ERASE)
              ? IAFC_OP_ERASE : IAFC_OP_WRITE;
            q_nxt.faddr = page_base(q_r.addr);
          end else if (i_mem_wdata[BIT_RD] && i_mem_wdata[BIT_RDEN]
              && q_r.st == IAFC_ST_IDLE
              && i_mem_wdata[BIT_MODE_HI:BIT_MODE_LO] == MODE_READ) begin
            q_nxt.rd = 1'b1;
            q_nxt.st = IAFC_ST_BUSY;
            q_nxt.op = IAFC_OP_READ;
            q_nxt.faddr = q_r.addr;
          end
        end
        IDX_CHIPRST: begin
          q_nxt.chip_key = i_mem_wdata;
          q_nxt.chip_rst = (i_mem_wdata == CHIP_RST_KEY);
        end
        IDX_BUFCLR: begin
          if (i_mem_wdata[0] && q_r.st == IAFC_ST_IDLE) begin
            q_nxt.buffer_clear_start = 1'b1;
            q_nxt.st = IAFC_ST_CLEAR;
          end
        end
        IDX_ADDR_LO: q_nxt.addr[7:0] = i_mem_wdata;
        IDX_ADDR_HI: q_nxt.addr[ADDR_W-1:8] = i_mem_wdata[ADDR_W-9:0];
        IDX_W0_LO: q_nxt.word[0][7:0] = i_mem_wdata;
        IDX_W0_HI: begin
          q_nxt.word[0][15:8] = i_mem_wdata;
          wbuf_bus.load = 1'b1;
          q_nxt.addr = ADDR_W'(q_r.addr + 1'b1);
        end
        default: begin
          // words one to three; in unlock they also carry the pattern
          q_nxt.word[3'(widx - IDX_W0_LO) >> 1][(widx[0] == IDX_W0_LO[0]) ? 0 : 8 +: 8]
            = i_mem_wdata;
          if (unlock_run && q_nxt.pen) begin
            if (pk == q_r.pat_idx && i_mem_wdata == UNLOCK_PAT[pk] && !q_r.pat_bad) begin
              q_nxt.pat_idx = 3'(q_r.pat_idx + 1'b1);
            end else begin
              q_nxt.pat_bad = 1'b1;
            end
          end
        end
      endcase
    end

    // --------------------------------------------------------------
    // unlock success: hardware set beats a software clear
    // --------------------------------------------------------------
    if (unlock_run && q_nxt.pen && !q_nxt.pat_bad && q_nxt.pat_idx == 3'(PAT_LEN)) begin
      q_nxt.wen = 1'b1;
      q_nxt.pen = 1'b0;
      q_nxt.pat_idx = '0;
    end

    // --------------------------------------------------------------
    // operation sequencer
    // --------------------------------------------------------------
    case (q_r.st)
      IAFC_ST_IDLE: begin
      end
      IAFC_ST_BUSY: begin
        if (i_flash_done) begin
          q_nxt.st = IAFC_ST_IDLE;
          q_nxt.wt = 1'b0;
          q_nxt.rd = 1'b0;
          if (q_r.op == IAFC_OP_READ) begin
            q_nxt.word[0] = i_flash_rdata;
          end
        end
      end
      IAFC_ST_CLEAR: begin
        wbuf_bus.clear = 1'b1;
        q_nxt.buffer_clear_start = 1'b0;
        q_nxt.st = IAFC_ST_IDLE;
      end
      default: begin
        q_nxt.st = IAFC_ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign o_mem_rdata = q_r.rdata;
  assign o_mem_hit = q_r.hit;
  assign o_flash_req = (q_r.st == IAFC_ST_BUSY);
  assign o_flash_op = q_r.op;
  assign o_flash_addr = q_r.faddr;
  assign o_flash_buf_data = wbuf_bus.rd_data;
  assign o_write_enabled = q_r.wen;
  assign o_chip_rst = q_r.chip_rst;
endmodule // iafc_ctrl

// ==== iafc_ctrl_assertions.sv ====
// Purpose: port-level checker for iafc_ctrl
// Assumes: one clock domain, reset asynchronous and active high
// Notes: sees only the top module's ports; bound at the foot of this file
module iafc_ctrl_checker
  import iafc_pkg::*;
#(
  parameter int ADDR_W = 15,
  parameter int DATA_W = 16,
  parameter int BUF_DEPTH = 64
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // data memory port
  input wire logic [7:0] i_mem_sector,
  input wire logic [7:0] i_mem_addr,
  input wire logic i_mem_wr,
  input wire logic i_mem_rd,
  input wire logic [7:0] i_mem_wdata,
  input wire logic [7:0] o_mem_rdata,
  input wire logic o_mem_hit,
  // subsystem clock
  input wire logic i_sub_clk,
  // flash array side
  input wire logic o_flash_req,
  input wire iafc_pkg::iafc_op_e o_flash_op,
  input wire logic [ADDR_W-1:0] o_flash_addr,
  input wire logic i_flash_done,
  input wire logic [DATA_W-1:0] i_flash_rdata,
  input wire logic [$clog2(BUF_DEPTH)-1:0] i_flash_buf_idx,
  input wire logic [DATA_W-1:0] o_flash_buf_data,
  // status and chip reset
  input wire logic o_write_enabled,
  input wire logic o_chip_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel;
  logic ctl_wr;
  logic key_wr;
  logic pat_end;
  assign sel = (i_mem_sector == 8'h01) && (i_mem_addr >= 8'h43) && (i_mem_addr <= 8'h4F);
  assign ctl_wr = i_mem_wr && sel && (i_mem_addr == 8'h43);
  assign key_wr = i_mem_wr && sel && (i_mem_addr == 8'h44) && (i_mem_wdata == 8'h55);
  assign pat_end = i_mem_wr && sel && (i_mem_addr == 8'h4F) && (i_mem_wdata == 8'h40);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ------
  // assertions
  // ------
  AST_HIT_ON_READ: assert property (i_mem_rd && sel |=> o_mem_hit)
    else $error("register read gave no hit");
  AST_NO_STRAY_HIT: assert property (!(i_mem_rd && sel) |=> !o_mem_hit)
    else $error("hit without a register read");
  AST_CHIP_RST_KEY: assert property (key_wr |=> o_chip_rst)
    else $error("chip reset missing after key write");
  // a second key write back to back legally stretches the pulse by one cycle
  AST_CHIP_RST_CAUSE: assert property (o_chip_rst |-> $past(key_wr) ##1 (!o_chip_rst || $past(key_wr)))
    else $error("chip reset without key or too long");
  AST_REQ_HOLD: assert property (o_flash_req && !i_flash_done |=>
    o_flash_req && $stable(o_flash_op) && $stable(o_flash_addr))
    else $error("flash request changed before done");
  AST_REQ_END: assert property (o_flash_req && i_flash_done |=> !o_flash_req)
    else $error("flash request stayed after done");
  AST_LOCKED_START: assert property (ctl_wr && !o_write_enabled && !o_flash_req
    && !i_mem_wdata[0] |=> !o_flash_req)
    else $error("start accepted while locked");
  AST_READ_GATE: assert property (ctl_wr && !i_mem_wdata[1] && !i_mem_wdata[2]
    && !o_flash_req |=> !o_flash_req)
    else $error("read started without read enable");
  AST_UNLOCK_CAUSE: assert property ($rose(o_write_enabled) |-> $past(pat_end))
    else $error("write enable set without pattern end");
  AST_WEN_CLEAR: assert property (ctl_wr && !i_mem_wdata[7] |=> !o_write_enabled)
    else $error("software clear of write enable ignored");
  cover property (o_chip_rst);
  cover property ($rose(o_write_enabled));
  cover property (o_flash_req && o_flash_op == IAFC_OP_ERASE);
endmodule // iafc_ctrl_checker

bind iafc_ctrl iafc_ctrl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .BUF_DEPTH(BUF_DEPTH))
  iafc_ctrl_checker_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_mem_sector(i_mem_sector),
  .i_mem_addr(i_mem_addr), .i_mem_wr(i_mem_wr), .i_mem_rd(i_mem_rd),
  .i_mem_wdata(i_mem_wdata), .o_mem_rdata(o_mem_rdata), .o_mem_hit(o_mem_hit),
  .i_sub_clk(i_sub_clk), .o_flash_req(o_flash_req), .o_flash_op(o_flash_op),
  .o_flash_addr(o_flash_addr), .i_flash_done(i_flash_done), .i_flash_rdata(i_flash_rdata),
  .i_flash_buf_idx(i_flash_buf_idx), .o_flash_buf_data(o_flash_buf_data),
  .o_write_enabled(o_write_enabled), .o_chip_rst(o_chip_rst));

// ==== iafc_flash_model.sv ====
// Purpose: behavioural flash array answering each request with one done pulse
// Assumes: request holds until done is seen
// Notes: LAT sets how slowly the array answers
module iafc_flash_model #(
  parameter int LAT = 3,
  parameter logic [15:0] RDATA = 16'hBEEF
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // request side
  input wire logic i_req,
  output logic o_done,
  output logic [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      o_done <= 1'b0;
    end else begin
      o_done <= i_req && !o_done && (cnt == LAT - 1);
      cnt <= (i_req && !o_done) ? cnt + 1 : 0;
    end
  end
  // data is only meaningful with done, so show the inverse otherwise
  assign o_rdata = o_done ? RDATA : ~RDATA;
endmodule // iafc_flash_model

// ==== iafc_pkg.sv ====
// Purpose: shared constants, types and decode helpers for the in_application_update
//          flash access control block
// Assumes: 8-bit data memory bus, registers in sector 1, word address 15 bits
// Notes:   register offsets within 43H..4FH follow the order of the register list
package iafc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int BUF_DEPTH = 64;
  localparam int PAGE_LSB = 6;

  localparam logic [7:0] REG_SECTOR = 8'h01;
  localparam logic [7:0] OFF_FIRST = 8'h43;
  localparam logic [7:0] OFF_LAST = 8'h4F;
  // register index = offset - 43H
  localparam logic [3:0] IDX_CTL = 4'h0;
  localparam logic [3:0] IDX_CHIPRST = 4'h1;
  localparam logic [3:0] IDX_BUFCLR = 4'h2;
  localparam logic [3:0] IDX_ADDR_LO = 4'h3;
  localparam logic [3:0] IDX_ADDR_HI = 4'h4;
  localparam logic [3:0] IDX_W0_LO = 4'h5;
  localparam logic [3:0] IDX_W0_HI = 4'h6;
  localparam logic [3:0] IDX_W1_LO = 4'h7;
  localparam logic [3:0] IDX_W3_HI = 4'hC;

  localparam int BIT_WEN = 7;
  localparam int BIT_MODE_HI = 6;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_PEN = 3;
  localparam int BIT_WT = 2;
  localparam int BIT_RDEN = 1;
  localparam int BIT_RD = 0;

  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  localparam logic [7:0] CHIP_RST_KEY = 8'h55;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int PAT_LEN = 6;
  localparam logic [PAT_LEN-1:0][7:0] UNLOCK_PAT = {8'h40, 8'hC3, 8'h09, 8'h0D, 8'h04, 8'h00};

  localparam int UNLOCK_TIMEOUT_US = 300;
  localparam int SUB_CLK_HZ = 32768;
  localparam int TMO_TICKS_RAW = (UNLOCK_TIMEOUT_US * SUB_CLK_HZ) / 1000000;
  localparam int TMO_TICKS = (TMO_TICKS_RAW < 1) ? 1 : TMO_TICKS_RAW;
  localparam int TMO_W = 16;

  typedef enum logic [1:0] {
    IAFC_OP_READ = 2'h0,
    IAFC_OP_ERASE = 2'h1,
    IAFC_OP_WRITE = 2'h2
  } iafc_op_e;

  typedef enum logic [1:0] {
    IAFC_ST_IDLE = 2'b00,
    IAFC_ST_BUSY = 2'b01,
    IAFC_ST_CLEAR = 2'b11
  } iafc_st_e;

  function automatic logic reg_hit(input logic [7:0] sector, input logic [7:0] addr);
    reg_hit = (sector == REG_SECTOR) && (addr >= OFF_FIRST) && (addr <= OFF_LAST);
  endfunction

  function automatic logic [3:0] reg_idx(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - OFF_FIRST;
    reg_idx = d[3:0];
  endfunction
endpackage

// ==== iafc_wbuf.sv ====
// Purpose: page write buffer of flip-flops
// Assumes: load and clear never matter in the same cycle; clear wins
// Notes:   whole buffer clears in one cycle, so a clear request ends next edge
module iafc_wbuf #(
  parameter int DW = 16,
  parameter int DEPTH = 64,
  parameter int IW = 6
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // control side
  iafc_buf_if.store bus
);
  import iafc_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rd_data;
  } iafc_wbuf_s;

  iafc_wbuf_s q_r;
  iafc_wbuf_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.rd_data = q_r.mem[bus.rd_idx];
    if (bus.clear) begin
      q_nxt.mem = '0;
    end else if (bus.load) begin
      q_nxt.mem[bus.load_idx] = bus.load_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign bus.rd_data = q_r.rd_data;
endmodule // iafc_wbuf

// ==== iap_flash_access_control_bench.sv ====
// Purpose: self-checking bench for iafc_ctrl through its data memory port
// Assumes: flash model answers three cycles after a request
// Notes: chip reset is left to the end since its effect on the chip is outside
module iap_flash_access_control_bench
  import iafc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  logic sub_clk = 1'b0;
  logic [7:0] sec = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [5:0] bidx = 6'h00;
  logic [7:0] rdata;
  logic hit, req, done, wen, crst;
  iafc_op_e op;
  logic [14:0] faddr;
  logic [15:0] read_start, bdata;
  logic [7:0] pat [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
  int n_fail = 0;
  int n_checks = 0;
  always #5 clk = ~clk;

  iafc_ctrl iafc_ctrl_i (.i_core_clk(clk), .i_rst(rst), .i_mem_sector(sec),
    .i_mem_addr(addr), .i_mem_wr(mem_wr), .i_mem_rd(mem_rd), .i_mem_wdata(wdata),
    .o_mem_rdata(rdata), .o_mem_hit(hit), .i_sub_clk(sub_clk), .o_flash_req(req),
    .o_flash_op(op), .o_flash_addr(faddr), .i_flash_done(done), .i_flash_rdata(read_start),
    .i_flash_buf_idx(bidx), .o_flash_buf_data(bdata), .o_write_enabled(wen),
    .o_chip_rst(crst));
  iafc_flash_model iafc_flash_model_i (.i_core_clk(clk), .i_rst(rst), .i_req(req),
    .o_done(done), .o_rdata(read_start));

  // ------
  // tasks
  // ------
  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sec <= 8'h01;
    addr <= a;
    wdata <= d;
    mem_wr <= 1'b1;
    @(posedge clk);
    mem_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] s, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sec <= s;
    addr <= a;
    mem_rd <= 1'b1;
    @(posedge clk);
    mem_rd <= 1'b0;
    #1;
    chk("hit", {15'h0, s == 8'h01 && a >= 8'h43 && a <= 8'h4F}, {15'h0, hit});
    if (hit === 1'b1) chk("register", {8'h00, exp}, {8'h00, rdata});
  endtask
  // bounded wait: a hung array must not stall the run
  task automatic wait_idle();
    int k;
    k = 0;
    // look just after each edge so the registered request has settled
    while (req !== 1'b0 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 50) begin
      n_fail++;
      $display("[ERR] flash request expected 0 seen %b", req);
      stop_test();
    end
  endtask

  // ------
  // sequence
  // ------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'h43; a <= 8'h4F; a++) reg_rd(8'h01, 8'(a), 8'h00);
    reg_rd(8'h00, 8'h43, 8'h00);
    reg_rd(8'h01, 8'h50, 8'h00);
    reg_wr(8'h45, 8'hFE);
    reg_rd(8'h01, 8'h45, 8'h00);
    reg_wr(8'h47, 8'hFF);
    reg_rd(8'h01, 8'h47, 8'h7F);
    reg_wr(8'h46, 8'hFF);
    reg_wr(8'h47, 8'h01);
    reg_wr(8'h48, 8'hA5);
    reg_rd(8'h01, 8'h46, 8'hFF);
    reg_wr(8'h49, 8'h5A);
    reg_rd(8'h01, 8'h46, 8'h00);
    reg_rd(8'h01, 8'h47, 8'h02);
    @(posedge clk);
    bidx <= 6'h3F;
    repeat (2) @(posedge clk);
    #1 chk("buffer word", 16'h5AA5, bdata);
    reg_wr(8'h45, 8'h01);
    reg_rd(8'h01, 8'h45, 8'h00);
    chk("cleared word", 16'h0000, bdata);
    reg_wr(8'h43, 8'h80);
    chk("write enabled", 16'h0, {15'h0, wen});
    reg_wr(8'h43, 8'h04);
    chk("locked request", 16'h0, {15'h0, req});
    reg_rd(8'h01, 8'h43, 8'h00);
    reg_wr(8'h43, 8'h31);
    chk("gated request", 16'h0, {15'h0, req});
    reg_wr(8'h43, 8'h33);
    chk("read request", 16'h1, {15'h0, req});
    chk("read op", {14'h0, IAFC_OP_READ}, {14'h0, op});
    chk("read addr", 16'h0200, {1'b0, faddr});
    wait_idle();
    reg_rd(8'h01, 8'h43, 8'h32);
    reg_rd(8'h01, 8'h48, 8'hEF);
    reg_rd(8'h01, 8'h49, 8'hBE);
    reg_wr(8'h46, 8'hC5);
    reg_wr(8'h47, 8'h02);
    reg_wr(8'h43, 8'h68);
    for (int i = 0; i < 6; i++) reg_wr(8'h4A + 8'(i), pat[i]);
    chk("unlocked", 16'h1, {15'h0, wen});
    reg_rd(8'h01, 8'h43, 8'hE0);
    reg_rd(8'h01, 8'h4F, 8'h40);
    foreach (pat[m]) if (m inside {2, 4, 5}) begin
      reg_wr(8'h43, {1'b1, 3'(m), 4'h6});
      chk("reserved mode", 16'h0, {15'h0, req});
    end
    reg_wr(8'h43, 8'hF6);
    chk("reserved mode", 16'h0, {15'h0, req});
    reg_wr(8'h43, 8'h94);
    chk("erase op", {14'h0, IAFC_OP_ERASE}, {14'h0, op});
    chk("page base", 16'h02C0, {1'b0, faddr});
    wait_idle();
    reg_rd(8'h01, 8'h43, 8'h90);
    reg_wr(8'h43, 8'h84);
    chk("write op", {14'h0, IAFC_OP_WRITE}, {14'h0, op});
    wait_idle();
    reg_wr(8'h43, 8'h00);
    chk("relocked", 16'h0, {15'h0, wen});
    reg_wr(8'h43, 8'h68);
    for (int i = 0; i < 6; i++) reg_wr(8'h4A + 8'(i), pat[i] ^ {7'h0, i == 1});
    chk("bad pattern", 16'h0, {15'h0, wen});
    reg_rd(8'h01, 8'h43, 8'h68);
    repeat (24) begin
      repeat (3) @(posedge clk);
      sub_clk <= ~sub_clk;
    end
    reg_rd(8'h01, 8'h43, 8'h60);
    reg_wr(8'h44, 8'h54);
    chk("no chip reset", 16'h0, {15'h0, crst});
    reg_rd(8'h01, 8'h44, 8'h54);
    reg_wr(8'h44, 8'h55);
    chk("chip reset", 16'h1, {15'h0, crst});
    stop_test();
  end
endmodule // iap_flash_access_control_bench
